// File: src/pls_top.sv
// Overview of operation
// - Legacy select cleared runs enhanced scheme
// - Each LED follows its own mode field
// - Shared behaviour register sets blink, stretch
// - Isolate, power-down or suspend blanks LEDs
// - Mode 0: link steady, activity blinks
// - Mode 1: gigabit link and activity only
// - Mode 2: 100 Mbps link and activity
// - Mode 3: 10 Mbps link and activity
// - Modes 4-6: speed pair link and activity
// - Mode 8: full duplex on, collisions blink
// - Mode 12: steady on during parallel fault
// - Suspend suppresses notifications until released
// - Suspend disables PHYs, registers stay alive
// - Suspend keeps interrupt output inactive
// - Suspend drops internal recovered clocks only
// - LED active level defaults from strap
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pls_top #(
    parameter int TICK_CYCLES = pls_pkg::TICK_CYCLES_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [pls_pkg::ADDR_W-1:0] ADDR,
    input wire logic [pls_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [pls_pkg::DATA_W-1:0] RD_DATA,
    input wire logic SUSPEND,
    input wire logic [3:0] LINK_UP,
    input wire logic [7:0] LINK_SPEED,
    input wire logic [3:0] ACTIVITY,
    input wire logic [3:0] FULL_DUPLEX,
    input wire logic [3:0] COLLISION,
    input wire logic [3:0] PD_FAULT,
    input wire logic [7:0] POL_STRAP,
    output logic [7:0] PORT_INDICATOR_OUTPUT,
    output logic [3:0] PHY_ENABLE,
    input wire logic [3:0] NOTIFY_IN,
    output logic [3:0] NOTIFY_OUT,
    input wire logic IRQ_IN,
    output logic IRQ_OUT,
    input wire logic [3:0] RCLK_INT,
    input wire logic [1:0] RCLK_CHAIN,
    output logic RCLK_OUT
);
    import pls_pkg::*;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [3:0] legacy_q; // Legacy scheme select per port
    logic [31:0] led_cfg_q; // Mode nibble per LED, LED1 low
    logic [3:0] isolate_ctrl_bit_q; // Isolate per port
    logic [3:0] pwr_down_q; // Power down per port
    logic [4:0] behavior_q; // Rate, stretch time, stretch enable
    logic [7:0] pol_q; // Active level per LED, 1 = high
    logic pol_loaded_q; // Strap already captured
    logic [2:0] rclk_sel_q; // Recovered clock source
    logic [7:0] lit; // Indicator states from the lanes

    // Register writes; access is never gated by suspend
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            legacy_q <= LED_CTRL1_RST;
            led_cfg_q <= LED_CTRL2_RST;
            isolate_ctrl_bit_q <= BASIC_RST[BASIC_ISO_LSB +: 4];
            pwr_down_q <= BASIC_RST[BASIC_PD_LSB +: 4];
            behavior_q <= BEHAVIOR_RST;
            rclk_sel_q <= RCLK_SEL_RST;
        end else if (WR_STB) begin
            if (ADDR == REG_LED_CTRL1) begin
                legacy_q <= WR_DATA[3:0];
            end else if (ADDR == REG_LED_CTRL2) begin
                led_cfg_q <= WR_DATA;
            end else if (ADDR == REG_BASIC_CTRL) begin
                isolate_ctrl_bit_q <= WR_DATA[BASIC_ISO_LSB +: 4];
                pwr_down_q <= WR_DATA[BASIC_PD_LSB +: 4];
            end else if (ADDR == REG_BEHAVIOR) begin
                behavior_q <= WR_DATA[4:0];
            end else if (ADDR == REG_RCLK_SEL) begin
                rclk_sel_q <= WR_DATA[2:0];
            end
        end
    end

    // Polarity: strap level is caught on the first edge after release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pol_q <= 8'h00;
            pol_loaded_q <= 1'b0;
        end else if (!pol_loaded_q) begin
            pol_q <= POL_STRAP;
            pol_loaded_q <= 1'b1;
        end else if (WR_STB && ADDR == REG_POLARITY) begin
            pol_q <= WR_DATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Register reads, data one cycle after the strobe
    // ----------------------------------------------------------------
    // Unmapped words and idle cycles read as zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RD_DATA <= 32'h0;
        end else if (!RD_STB) begin
            RD_DATA <= 32'h0;
        end else if (ADDR == REG_LED_CTRL1) begin
            RD_DATA <= {28'h0, legacy_q};
        end else if (ADDR == REG_LED_CTRL2) begin
            RD_DATA <= led_cfg_q;
        end else if (ADDR == REG_BASIC_CTRL) begin
            RD_DATA <= {24'h0, pwr_down_q, isolate_ctrl_bit_q};
        end else if (ADDR == REG_BEHAVIOR) begin
            RD_DATA <= {27'h0, behavior_q};
        end else if (ADDR == REG_POLARITY) begin
            RD_DATA <= {24'h0, pol_q};
        end else if (ADDR == REG_RCLK_SEL) begin
            RD_DATA <= {29'h0, rclk_sel_q};
        end else if (ADDR == REG_STATUS) begin
            RD_DATA <= {19'h0, PHY_ENABLE, SUSPEND, lit};
        end else begin
            RD_DATA <= 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    logic [15:0] tick_cnt_q; // Cycles within one tick
    logic tick; // One-cycle enable every millisecond
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    assign tick = (tick_cnt_q == TICK_LAST);

    // Free-running divider; keeps LEDs of all ports in phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_q <= 16'h0;
        end else if (tick) begin
            tick_cnt_q <= 16'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Shared blink phase
    // ----------------------------------------------------------------
    logic [7:0] blink_half; // Half period in ticks
    logic [7:0] blink_cnt_q; // Ticks in current half
    logic blink_ph_q; // Blink phase, 1 = lit half

    // Rate select from the behaviour register
    always_comb begin
        case (behavior_q[BEH_RATE_LSB +: 2])
            2'h0: blink_half = BLINK_HALF_MS0;
            2'h1: blink_half = BLINK_HALF_MS1;
            2'h2: blink_half = BLINK_HALF_MS2;
            default: blink_half = BLINK_HALF_MS3;
        endcase
    end

    // A rate change takes effect at the next half boundary at most
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            blink_cnt_q <= 8'h0;
            blink_ph_q <= 1'b1;
        end else if (tick) begin
            if (blink_cnt_q >= blink_half - 8'h1) begin
                blink_cnt_q <= 8'h0;
                blink_ph_q <= ~blink_ph_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 8'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pulse stretch for activity and collision
    // ----------------------------------------------------------------
    logic [7:0] stretch_len; // Stretch length in ticks
    logic [7:0] act_str; // Even: activity, odd: collision

    // Stretch time from the behaviour register
    always_comb begin
        case (behavior_q[BEH_STR_LSB +: 2])
            2'h0: stretch_len = STRETCH_MS0;
            2'h1: stretch_len = STRETCH_MS1;
            2'h2: stretch_len = STRETCH_MS2;
            default: stretch_len = STRETCH_MS3;
        endcase
    end

    // Short frames would otherwise flash too briefly to see
    for (genvar k = 0; k < NUM_LEDS; k++) begin : g_str
        logic [7:0] cnt_q; // Remaining stretch ticks
        logic ev; // Raw event level
        assign ev = (k % 2 == 1) ? COLLISION[k / 2] : ACTIVITY[k / 2];
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                cnt_q <= 8'h0;
            end else if (ev) begin
                cnt_q <= stretch_len;
            end else if (tick && cnt_q != 8'h0) begin
                cnt_q <= cnt_q - 8'h1;
            end
        end
        assign act_str[k] = ev || (behavior_q[BEH_STR_EN] && cnt_q != 8'h0);
    end

    // ----------------------------------------------------------------
    // Indicator lanes, two per port
    // ----------------------------------------------------------------
    logic [3:0] blank; // Per-port forced-off condition

    assign blank = isolate_ctrl_bit_q | pwr_down_q | {4{SUSPEND}};

    for (genvar i = 0; i < NUM_LEDS; i++) begin : g_lane
        pls_lane u_lane (
            .clk(CLK),
            .rst(RST),
            .cfg(led_cfg_q[4 * i +: 4]),
            .legacy(legacy_q[i / 2]),
            .off(blank[i / 2]),
            .pol(pol_q[i]),
            .blink_ph(blink_ph_q),
            .link(LINK_UP[i / 2]),
            .speed(LINK_SPEED[2 * (i / 2) +: 2]),
            .act(act_str[2 * (i / 2)]),
            .full_dup(FULL_DUPLEX[i / 2]),
            .col(act_str[2 * (i / 2) + 1]),
            .pdf(PD_FAULT[i / 2]),
            .lit_q(lit[i]),
            .led_q(PORT_INDICATOR_OUTPUT[i])
        );
    end

    // ----------------------------------------------------------------
    // Suspend gating of PHY, notifications and interrupt
    // ----------------------------------------------------------------
    // Registered so the gate is glitch free at the pins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PHY_ENABLE <= 4'h0;
            NOTIFY_OUT <= 4'h0;
            IRQ_OUT <= 1'b0;
        end else if (SUSPEND) begin
            PHY_ENABLE <= 4'h0;
            NOTIFY_OUT <= 4'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            PHY_ENABLE <= 4'hf;
            NOTIFY_OUT <= NOTIFY_IN;
            IRQ_OUT <= IRQ_IN;
        end
    end

    // ----------------------------------------------------------------
    // Recovered clock selector
    // ----------------------------------------------------------------
    // Sampled path; chain inputs stay usable while suspended
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RCLK_OUT <= 1'b0;
        end else if (rclk_sel_q < RCLK_CHAIN_BASE) begin
            RCLK_OUT <= RCLK_INT[rclk_sel_q[1:0]] && !SUSPEND;
        end else if (rclk_sel_q == RCLK_CHAIN_BASE) begin
            RCLK_OUT <= RCLK_CHAIN[0];
        end else if (rclk_sel_q == RCLK_CHAIN_BASE + 3'h1) begin
            RCLK_OUT <= RCLK_CHAIN[1];
        end else begin
            RCLK_OUT <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_susp_int;
        SUSPEND && rclk_sel_q < RCLK_CHAIN_BASE;
    endsequence

    sequence s_susp_chain0;
        SUSPEND && rclk_sel_q == RCLK_CHAIN_BASE;
    endsequence

    a_notify_quiet: assert property (
        @(posedge CLK) disable iff (RST)
        SUSPEND |=> NOTIFY_OUT == 4'h0)
        else $error("Notification during suspend");
    a_notify_resume: assert property (
        @(posedge CLK) disable iff (RST)
        !SUSPEND |=> NOTIFY_OUT == $past(NOTIFY_IN))
        else $error("Notification lost after suspend");
    a_phy_held: assert property (
        @(posedge CLK) disable iff (RST)
        SUSPEND |=> PHY_ENABLE == 4'h0)
        else $error("PHY enabled during suspend");
    a_irq_quiet: assert property (
        @(posedge CLK) disable iff (RST)
        SUSPEND [*2] |-> !IRQ_OUT)
        else $error("Interrupt during suspend");
    a_rclk_drop: assert property (
        @(posedge CLK) disable iff (RST)
        s_susp_int |=> !RCLK_OUT)
        else $error("Internal recovered clock passed");
    a_rclk_chain: assert property (
        @(posedge CLK) disable iff (RST)
        s_susp_chain0 |=> RCLK_OUT == $past(RCLK_CHAIN[0]))
        else $error("Chain clock blocked in suspend");
    a_status_read: assert property (
        @(posedge CLK) disable iff (RST)
        (RD_STB && ADDR == REG_STATUS) |=>
            RD_DATA[STAT_SUSP] == $past(SUSPEND))
        else $error("Status read wrong during suspend");
    a_blank_pins: assert property (
        @(posedge CLK) disable iff (RST)
        SUSPEND ##1 SUSPEND |-> lit == 8'h00)
        else $error("LED lit while suspended");
    a_strap_load: assert property (
        @(posedge CLK) disable iff (RST)
        !pol_loaded_q |=> pol_q == $past(POL_STRAP))
        else $error("Strap polarity not captured");

    // Release side of the gates, then read, write and blink checks; a stuck gate would slip past the above
    a_phy_resume: assert property (
        @(posedge CLK) disable iff (RST)
        !SUSPEND |=> PHY_ENABLE == 4'hf)
        else $error("PHY not restarted after suspend");
    a_irq_follow: assert property (
        @(posedge CLK) disable iff (RST)
        !SUSPEND |=> IRQ_OUT == $past(IRQ_IN))
        else $error("Interrupt lost outside suspend");
    a_read_idle: assert property (
        @(posedge CLK) disable iff (RST)
        !RD_STB |=> RD_DATA == 32'h0)
        else $error("Read data stands beyond one cycle");
    a_cfg_write: assert property (
        @(posedge CLK) disable iff (RST)
        (WR_STB && ADDR == REG_LED_CTRL2) |=> led_cfg_q == $past(WR_DATA))
        else $error("Mode register write lost");
    a_blink_hold: assert property (
        @(posedge CLK) disable iff (RST)
        !tick |=> $stable(blink_ph_q))
        else $error("Blink phase moved between ticks");

endmodule : pls_top

`default_nettype wire

// File: src/pls_pkg.sv
package pls_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 4; // Ports served
    localparam int NUM_LEDS = 8; // Two indicators per port
    localparam int DATA_W = 32; // Register bus data width
    localparam int ADDR_W = 4; // Register word index width

    // ----------------------------------------------------------------
    // Timing: one millisecond tick drives blink and stretch
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50; // 20 MHz system clock
    localparam int TICK_NS = 1000000; // Tick period, 1 ms
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] BLINK_HALF_MS0 = 8'hfa; // 250 ms half period
    localparam logic [7:0] BLINK_HALF_MS1 = 8'h7d; // 125 ms half period
    localparam logic [7:0] BLINK_HALF_MS2 = 8'h3f; // 63 ms half period
    localparam logic [7:0] BLINK_HALF_MS3 = 8'h20; // 32 ms half period
    localparam logic [7:0] STRETCH_MS0 = 8'h14; // 20 ms stretch
    localparam logic [7:0] STRETCH_MS1 = 8'h28; // 40 ms stretch
    localparam logic [7:0] STRETCH_MS2 = 8'h50; // 80 ms stretch
    localparam logic [7:0] STRETCH_MS3 = 8'ha0; // 160 ms stretch

    // ----------------------------------------------------------------
    // Register word indices
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_LED_CTRL1 = 4'h0; // Legacy select per port
    localparam logic [3:0] REG_LED_CTRL2 = 4'h1; // Mode nibble per LED
    localparam logic [3:0] REG_BASIC_CTRL = 4'h2; // Isolate, power down
    localparam logic [3:0] REG_BEHAVIOR = 4'h3; // Blink and stretch
    localparam logic [3:0] REG_POLARITY = 4'h4; // Active level per LED
    localparam logic [3:0] REG_RCLK_SEL = 4'h5; // Recovered clock source
    localparam logic [3:0] REG_STATUS = 4'h6; // Read-only state

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BASIC_ISO_LSB = 0; // Isolate bits [3:0]
    localparam int BASIC_PD_LSB = 4; // Power-down bits [7:4]
    localparam int BEH_RATE_LSB = 0; // Blink rate [1:0]
    localparam int BEH_STR_LSB = 2; // Stretch time [3:2]
    localparam int BEH_STR_EN = 4; // Stretch enable
    localparam int STAT_SUSP = 8; // Suspend level in status
    localparam logic [3:0] LED_CTRL1_RST = 4'h0; // Enhanced scheme
    localparam logic [31:0] LED_CTRL2_RST = 32'h0; // Mode 0 everywhere
    localparam logic [7:0] BASIC_RST = 8'h00; // Running
    localparam logic [4:0] BEHAVIOR_RST = 5'h10; // Stretch on, slow
    localparam logic [2:0] RCLK_SEL_RST = 3'h0; // Port 0 internal

    // ----------------------------------------------------------------
    // Indicator modes and speed codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_LINK_ACT = 4'h0;
    localparam logic [3:0] MODE_DUPLEX_COL = 4'h8;
    localparam logic [3:0] MODE_COLLISION = 4'h9;
    localparam logic [3:0] MODE_ACTIVITY = 4'ha;
    localparam logic [3:0] MODE_PD_FAULT = 4'hc;
    localparam logic [3:0] MODE_FORCE_OFF = 4'he;
    localparam logic [3:0] MODE_FORCE_ON = 4'hf;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [2:0] RCLK_CHAIN_BASE = 3'h4; // Chain inputs 4, 5

endpackage : pls_pkg

// File: src/pls_lane.sv
`timescale 1ns/10ps
`default_nettype none

module pls_lane (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] cfg,
    input wire logic legacy,
    input wire logic off,
    input wire logic pol,
    input wire logic blink_ph,
    input wire logic link,
    input wire logic [1:0] speed,
    input wire logic act,
    input wire logic full_dup,
    input wire logic col,
    input wire logic pdf,
    output logic lit_q,
    output logic led_q
);
    import pls_pkg::*;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic lit_d; // Indicator lit this cycle
    logic [2:0] spd_mask; // Speeds that qualify: {1000,100,10}
    logic spd_hit; // Current speed qualifies
    logic link_view; // Steady on idle, blink on activity

    // Speed pairs for the single and dual speed modes
    always_comb begin
        case (cfg)
            4'h1: spd_mask = 3'h4;
            4'h2: spd_mask = 3'h2;
            4'h3: spd_mask = 3'h1;
            4'h4: spd_mask = 3'h6;
            4'h5: spd_mask = 3'h5;
            4'h6: spd_mask = 3'h3;
            default: spd_mask = 3'h7;
        endcase
    end

    // Explicit compare keeps speed code 3 from indexing past the mask
    assign spd_hit = (speed == SPEED_10 && spd_mask[0])
        || (speed == SPEED_100 && spd_mask[1])
        || (speed == SPEED_1000 && spd_mask[2]);
    assign link_view = act ? blink_ph : 1'b1;

    // Status selected per LED by its own field
    always_comb begin
        case (cfg)
            MODE_LINK_ACT: lit_d = link && link_view;
            4'h1, 4'h2, 4'h3: lit_d = link && spd_hit && link_view;
            4'h4, 4'h5, 4'h6: lit_d = link && spd_hit && link_view;
            MODE_DUPLEX_COL: lit_d = link && (full_dup || (col && blink_ph));
            MODE_COLLISION: lit_d = col && blink_ph;
            MODE_ACTIVITY: lit_d = act && blink_ph;
            MODE_PD_FAULT: lit_d = pdf;
            MODE_FORCE_OFF: lit_d = 1'b0;
            MODE_FORCE_ON: lit_d = 1'b1;
            default: lit_d = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Output stage: blanking and active level
    // ----------------------------------------------------------------
    // Legacy select and the blanking sources both darken the pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lit_q <= 1'b0;
            led_q <= 1'b0;
        end else if (legacy || off) begin
            lit_q <= 1'b0;
            led_q <= ~pol;
        end else begin
            lit_q <= lit_d;
            led_q <= lit_d ? pol : ~pol;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_live;
        !off && !legacy;
    endsequence

    a_blank_dark: assert property (
        @(posedge clk) disable iff (rst)
        (off || legacy) |=> !lit_q)
        else $error("LED lit while blanked");
    a_force_on: assert property (
        @(posedge clk) disable iff (rst)
        (cfg == MODE_FORCE_ON) ##0 s_live |=> lit_q)
        else $error("Force-on mode dark");
    a_reserved_dark: assert property (
        @(posedge clk) disable iff (rst)
        (cfg == 4'h7 || cfg == 4'hb || cfg == 4'hd) |=> !lit_q)
        else $error("Reserved mode lit");
    a_fault_follow: assert property (
        @(posedge clk) disable iff (rst)
        (cfg == MODE_PD_FAULT) ##0 s_live |=> lit_q == $past(pdf))
        else $error("Fault mode does not follow fault");
    a_idle_link_on: assert property (
        @(posedge clk) disable iff (rst)
        (cfg == MODE_LINK_ACT && link && !act) ##0 s_live |=> lit_q)
        else $error("Idle link not steady on");
    a_pin_level: assert property (
        @(posedge clk) disable iff (rst)
        1'b1 |=> led_q == (lit_q ? $past(pol) : !$past(pol)))
        else $error("Pin level ignores polarity");

endmodule : pls_lane

`default_nettype wire

// File: bench/pls_partner.sv
`timescale 1ns/10ps
`default_nettype none

// Board side: indicator lamps and the suspend switch
module pls_partner (
    input wire logic [7:0] pins,
    input wire logic [7:0] pol,
    input wire logic susp_req,
    output logic [7:0] lamp,
    output logic susp_pin
);
    // Lamp glows only while its pin sits at the strapped active level
    assign lamp = ~(pins ^ pol);
    // Switch holds the suspend pin high while requested
    assign susp_pin = susp_req;
endmodule : pls_partner

`default_nettype wire

// File: bench/test_pls_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module test_pls_top;
    import pls_pkg::*;
    logic clk, rst, wr_stb, rd_stb, susp_req, irq_in, irq_out, rclk_out;
    logic susp_pin;
    logic [3:0] addr, link_up, act, fdx, col, pdf, nin, nout, rint, phy_en;
    logic [31:0] wr_data, rd_data, d;
    logic [7:0] speed, pins, lamp;
    logic [1:0] chain;
    int mismatches = 0;
    int checks = 0;
    int n;
    localparam logic [7:0] STRAP = 8'hfd; // Port 0 LED2 active low
    // Steady lamp per mode, for 10, 100 and 1000 Mbps links
    logic [15:0] exp_tab [3] = '{16'h9169, 16'h9155, 16'h9133};
    pls_top #(.TICK_CYCLES(4)) pls_top_i (.CLK(clk), .RST(rst),
        .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .RD_DATA(rd_data), .SUSPEND(susp_pin), .LINK_UP(link_up),
        .LINK_SPEED(speed), .ACTIVITY(act), .FULL_DUPLEX(fdx),
        .COLLISION(col), .PD_FAULT(pdf), .POL_STRAP(STRAP),
        .PORT_INDICATOR_OUTPUT(pins), .PHY_ENABLE(phy_en), .NOTIFY_IN(nin),
        .NOTIFY_OUT(nout), .IRQ_IN(irq_in), .IRQ_OUT(irq_out),
        .RCLK_INT(rint), .RCLK_CHAIN(chain), .RCLK_OUT(rclk_out));
    pls_partner pls_partner_i (.pins(pins), .pol(STRAP),
        .susp_req(susp_req), .lamp(lamp), .susp_pin(susp_pin));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        v = rd_data;
    endtask : rd
    // Lamp transitions seen over 1024 cycles
    task automatic edges(output int k);
        logic p;
        k = 0;
        p = lamp[0];
        repeat (1024) begin
            step(1);
            if (lamp[0] !== p) k++;
            p = lamp[0];
        end
    endtask : edges
    task automatic t_reset;
        rd(REG_BEHAVIOR, d);
        `CHK(d, 32'h10)
        rd(REG_POLARITY, d);
        `CHK(d[7:0], STRAP)
        rd(4'h7, d);
        `CHK(d, 32'h0)
        `CHK(pins, ~STRAP)
    endtask : t_reset
    task automatic t_modes;
        // Stimulus moves only on a rising edge
        @(posedge clk);
        link_up <= 4'h1;
        fdx <= 4'h1;
        pdf <= 4'h1;
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            speed[1:0] <= 2'(s);
            for (int m = 0; m < 16; m++) begin
                wr(REG_LED_CTRL2, {24'h0, 4'he, 4'(m)});
                step(3);
                `CHK(lamp[0], exp_tab[s][m])
                `CHK(lamp[0], exp_tab[s][m])
                `CHK(lamp[1], 1'b0)
            end
        end
    endtask : t_modes
    // Half-duplex link with activity, collisions and a fault
    task automatic t_blink;
        logic [3:0] md [6] = '{4'h0, 4'ha, 4'h9, 4'h8, 4'hc, 4'h0};
        int lo [6] = '{7, 7, 7, 7, 0, 3};
        int hi [6] = '{9, 9, 9, 9, 0, 5};
        @(posedge clk);
        act <= 4'h1;
        col <= 4'h1;
        fdx <= 4'h0;
        for (int i = 0; i < 6; i++) begin
            wr(REG_BEHAVIOR, (i == 5) ? 32'h12 : 32'h13);
            wr(REG_LED_CTRL2, {28'h0, md[i]});
            step(3);
            edges(n);
            `CHK(n inside {[lo[i]:hi[i]]}, 1'b1)
        end
    endtask : t_blink
    task automatic t_blank;
        logic [3:0] ad [3] = '{REG_BASIC_CTRL, REG_BASIC_CTRL, REG_LED_CTRL1};
        logic [31:0] dv [3] = '{32'h1, 32'h10, 32'h1};
        wr(REG_LED_CTRL2, 32'hef);
        for (int i = 0; i < 3; i++) begin
            wr(ad[i], dv[i]);
            step(3);
            `CHK(lamp[0], 1'b0)
            wr(ad[i], 32'h0);
            step(3);
            `CHK(lamp[0], 1'b1)
        end
    endtask : t_blank
    task automatic t_suspend;
        @(posedge clk);
        nin <= 4'hf;
        irq_in <= 1'b1;
        rint <= 4'hf;
        chain <= 2'h3;
        wr(REG_RCLK_SEL, 32'h0);
        step(3);
        `CHK({nout, irq_out, rclk_out}, 6'h3f)
        @(posedge clk);
        susp_req <= 1'b1;
        step(3);
        `CHK({lamp[0], phy_en}, 5'h0)
        `CHK({nout, irq_out, rclk_out}, 6'h0)
        wr(REG_RCLK_SEL, 32'h4);
        step(3);
        `CHK(rclk_out, 1'b1)
        rd(REG_STATUS, d);
        `CHK(d[12:8], 5'h01)
        @(posedge clk);
        susp_req <= 1'b0;
        step(3);
        `CHK({nout, irq_out, phy_en, lamp[0]}, 10'h3ff)
    endtask : t_suspend
    task automatic end_sim;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        {rst, wr_stb, rd_stb, susp_req, irq_in} = 5'h10;
        {addr, link_up, act, fdx, col, pdf, nin, rint} = '0;
        {wr_data, speed, chain} = {32'h0, 8'hff, 2'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_blink();
        t_blank();
        t_suspend();
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule : test_pls_top

`default_nettype wire
